// [hdl/toei_req_cell.sv]
/*
 * One self-clearing error request bit: set by a software write of 1,
 * cleared by the datapath once its error has gone out.
 * Assumes set and clear are single-cycle pulses on ref_clk.
 */
`timescale 1ns/100ps
module toei_req_cell (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control
	input wire logic set_req,
	input wire logic clr_req,
	// State
	output logic armed
);

	// A write landing with the clear keeps the request pending
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			armed <= 1'b0;
		end else if (set_req) begin
			armed <= 1'b1;
		end else if (clr_req) begin
			armed <= 1'b0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_set_wins_clear: assert property (set_req |=> armed)
		else $error("request lost when set and clear coincide");
	chk_clear_takes: assert property (clr_req && !set_req |=> !armed)
		else $error("request not cleared after insertion");

endmodule

// [hdl/toei_top.sv]
/*
 * Transmit overhead error insertion for one framer channel, with its
 * Avalon-MM register slave. Bits from the frame generator pass through one
 * register stage and overhead bits are corrupted on request.
 * Assumes the generator tags each bit with its overhead position, marks the
 * first and last bit of multi-bit groups and gives the bit index in a group.
 * rx_err_detected comes from receive logic on the same clock.
 */
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps

module toei_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Bit stream from the frame generator
	input wire logic tx_bit_in,
	input wire logic tx_bit_valid,
	input wire logic [3:0] ovh_kind,
	input wire logic ovh_first,
	input wire logic ovh_last,
	input wire logic [1:0] ovh_idx,
	// Receive side error indication for FEBE generation
	input wire logic rx_err_detected,
	// Bit stream towards the line encoder
	output logic tx_bit_out,
	output logic tx_bit_out_valid
);

	logic [7:0] armed;
	logic [7:0] set_vec;
	logic [7:0] done_vec;
	logic [1:0] mode;
	logic febe_auto;
	logic [2:0] far_end_code_field;
	logic [7:0] ins_count;
	logic grp_p;
	logic grp_cp;
	logic grp_x;
	logic grp_fe;
	logic febe_err_l;
	logic acc_now;
	logic ds3;
	logic cbit;
	logic g751;
	logic g832;
	logic inv_f;
	logic inv_m;
	logic inv_p;
	logic inv_pm;
	logic inv_cp;
	logic inv_x;
	logic inv_xm;
	logic fe_ds3;
	logic inv_e3fa;
	logic inv_abit;
	logic inv_bip;
	logic inv_rdi;
	logic inv_rei;
	logic invert;
	logic febe_err_now;
	logic next_out;

	// Tag match on a valid bit, shared by all insertion terms
	function automatic logic at_kind(input logic vld, input logic [3:0] kind,
		input toei_pkg::toei_kind_t want);
		at_kind = vld && (kind == want);
	endfunction

	// Mode decode
	assign ds3 = (mode == toei_pkg::MODE_DS3_M13) || (mode == toei_pkg::MODE_DS3_CBIT);
	assign cbit = (mode == toei_pkg::MODE_DS3_CBIT);
	assign g751 = (mode == toei_pkg::MODE_E3_G751);
	assign g832 = (mode == toei_pkg::MODE_E3_G832);

	// Bus access completes in the cycle waitrequest is low
	assign acc_now = (avs_read || avs_write) && !avs_waitrequest;

	// One wait state per access, then a single ready cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	// Read data prepared during the wait state; unmapped reads give zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			if (avs_address == toei_pkg::OFS_ERR_CTRL) begin
				avs_readdata <= {24'h00_0000, armed}; // pending requests for polling
			end else if (avs_address == toei_pkg::OFS_CONFIG) begin
				avs_readdata <= {26'h000_0000, far_end_code_field, febe_auto, mode};
			end else if (avs_address == toei_pkg::OFS_STATUS) begin
				avs_readdata <= {24'h00_0000, ins_count};
			end else begin
				avs_readdata <= 32'h0000_0000;
			end
		end
	end

	// Request bits are write-one-to-set from lane 0 only
	assign set_vec = (acc_now && avs_write && avs_byteenable[0]
		&& (avs_address == toei_pkg::OFS_ERR_CTRL)) ? avs_writedata[7:0] : 8'h00;

	// Configuration register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode <= toei_pkg::RST_MODE;
			febe_auto <= toei_pkg::RST_FEBE_AUTO;
			far_end_code_field <= toei_pkg::RST_CODE;
		end else if (acc_now && avs_write && avs_byteenable[0]
			&& (avs_address == toei_pkg::OFS_CONFIG)) begin
			mode <= avs_writedata[toei_pkg::CFG_MODE_LSB +: 2];
			febe_auto <= avs_writedata[toei_pkg::CFG_FEBE_AUTO];
			far_end_code_field <= avs_writedata[toei_pkg::CFG_CODE_LSB +: 3];
		end
	end

	// One arm cell per error; each clears on its own completion
	genvar gi;
	generate
		for (gi = 0; gi < toei_pkg::REQ_COUNT; gi++) begin : g_req
			toei_req_cell u_cell (
				.ref_clk(ref_clk),
				.rst(rst),
				.set_req(set_vec[gi]),
				.clr_req(done_vec[gi]),
				.armed(armed[gi])
			);
		end
	endgenerate

	// DS3 single-bit errors
	assign inv_f = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_F) && ds3
		&& armed[toei_pkg::REQ_FRAME_BIT];
	assign inv_m = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_M) && ds3
		&& armed[toei_pkg::REQ_MFRAME_BIT];

	// Parity group starts only on the first P-bit so a whole frame is hit
	assign inv_p = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_P) && ds3
		&& (grp_p || (ovh_first && armed[toei_pkg::REQ_PARITY]));
	// Mismatch yields to the pair so the two never cancel on one bit
	assign inv_pm = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_P) && ds3 && !inv_p
		&& !grp_p && armed[toei_pkg::REQ_PARITY_MIS];
	assign inv_cp = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_CP) && cbit
		&& (grp_cp || (ovh_first && armed[toei_pkg::REQ_PATH_PARITY]));
	assign inv_x = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_X) && ds3
		&& (grp_x || (ovh_first && armed[toei_pkg::REQ_REMOTE_ALARM]));
	assign inv_xm = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_X) && ds3 && !inv_x
		&& !grp_x && armed[toei_pkg::REQ_XBIT_MIS];
	// FEBE in M13/M23 is left alone: no far-end field exists there
	assign fe_ds3 = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_FEBE) && cbit
		&& (grp_fe || (ovh_first && armed[toei_pkg::REQ_FAR_END]));

	// E3 errors, all single-bit
	assign inv_e3fa = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_FAS) && (g751 || g832)
		&& ovh_first && armed[toei_pkg::REQ_FRAME_BIT];
	assign inv_abit = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_ABIT) && g751
		&& armed[toei_pkg::REQ_REMOTE_ALARM];
	assign inv_bip = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_BIP) && g832
		&& ovh_first && armed[toei_pkg::REQ_PARITY];
	assign inv_rdi = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_RDI) && g832
		&& armed[toei_pkg::REQ_REMOTE_ALARM];
	// Inverted whatever the bit's source was
	assign inv_rei = at_kind(tx_bit_valid, ovh_kind, toei_pkg::OVH_REI) && g832
		&& armed[toei_pkg::REQ_FAR_END];

	// Any kind not matched for the mode leaves the bit untouched
	assign invert = inv_f || inv_m || inv_p || inv_pm || inv_cp || inv_x || inv_xm
		|| inv_e3fa || inv_abit || inv_bip || inv_rdi || inv_rei
		|| (fe_ds3 && !febe_auto);

	// Error sampled once per M-frame so the three bits agree
	assign febe_err_now = grp_fe ? febe_err_l : rx_err_detected;

	// Output bit selection
	always_comb begin
		next_out = tx_bit_in ^ invert;
		if (fe_ds3 && febe_auto) begin
			next_out = febe_err_now ? toei_pkg::FEBE_NO_ERR_CODE[2 - ovh_idx]
				: far_end_code_field[2 - ovh_idx];
		end
	end

	// Completion of each request
	always_comb begin
		done_vec = 8'h00;
		done_vec[toei_pkg::REQ_FRAME_BIT] = inv_f || inv_e3fa;
		done_vec[toei_pkg::REQ_MFRAME_BIT] = inv_m;
		done_vec[toei_pkg::REQ_PARITY] = (inv_p && ovh_last) || inv_bip;
		done_vec[toei_pkg::REQ_PARITY_MIS] = inv_pm;
		done_vec[toei_pkg::REQ_PATH_PARITY] = inv_cp && ovh_last;
		done_vec[toei_pkg::REQ_REMOTE_ALARM] = (inv_x && ovh_last) || inv_abit || inv_rdi;
		done_vec[toei_pkg::REQ_XBIT_MIS] = inv_xm;
		done_vec[toei_pkg::REQ_FAR_END] = (fe_ds3 && ovh_last) || inv_rei;
	end

	// Multi-bit group trackers, held from first to last bit of a group
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			grp_p <= 1'b0;
			grp_cp <= 1'b0;
			grp_x <= 1'b0;
			grp_fe <= 1'b0;
			febe_err_l <= 1'b0;
		end else begin
			if (inv_p) grp_p <= !ovh_last;
			if (inv_cp) grp_cp <= !ovh_last;
			if (inv_x) grp_x <= !ovh_last;
			if (fe_ds3) grp_fe <= !ovh_last;
			if (fe_ds3 && !grp_fe) febe_err_l <= rx_err_detected;
		end
	end

	// Output stage; one cycle of latency for every bit
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx_bit_out <= 1'b0;
			tx_bit_out_valid <= 1'b0;
		end else begin
			tx_bit_out <= next_out;
			tx_bit_out_valid <= tx_bit_valid;
		end
	end

	// Completed insertions, wrapping; lets software see progress
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ins_count <= toei_pkg::RST_INS_COUNT;
		end else if (done_vec != 8'h00) begin
			ins_count <= ins_count + 8'h01;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_fbit_inverted: assert property (inv_f |=> tx_bit_out == !$past(tx_bit_in))
		else $error("F-bit not inverted");
	chk_mbit_single: assert property (inv_m |=> !armed[toei_pkg::REQ_MFRAME_BIT]
		|| $past(set_vec[toei_pkg::REQ_MFRAME_BIT]))
		else $error("M-bit request still pending after insertion");
	chk_parity_pair: assert property (inv_p && ovh_first && !ovh_last |=> grp_p)
		else $error("parity group not held for second P-bit");
	chk_parity_mis_one: assert property (inv_pm |=> tx_bit_out != $past(tx_bit_in)
		&& (!armed[toei_pkg::REQ_PARITY_MIS] || $past(set_vec[toei_pkg::REQ_PARITY_MIS])))
		else $error("mismatch bit not inverted or request not cleared");
	chk_cp_group: assert property (inv_cp && ovh_last |=> !grp_cp)
		else $error("CP group not closed on third bit");
	chk_xbit_pair: assert property (inv_x |=> tx_bit_out != $past(tx_bit_in))
		else $error("X-bit not inverted");
	chk_febe_code: assert property (fe_ds3 && febe_auto && febe_err_now |=> tx_bit_out)
		else $error("FEBE not 1 with error detected");
	chk_febe_m13_quiet: assert property (tx_bit_valid
		&& mode == toei_pkg::MODE_DS3_M13 && ovh_kind == toei_pkg::OVH_FEBE
		|=> tx_bit_out == $past(tx_bit_in))
		else $error("FEBE altered in M13 mode");
	chk_payload_clean: assert property (!invert && !fe_ds3
		|=> tx_bit_out == $past(tx_bit_in))
		else $error("bit altered without a request");
	chk_bus_ready: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest timing broken");

	cov_fbit_insert: cover property (inv_f);
	cov_parity_pair: cover property (inv_p && ovh_first ##[1:200] inv_p && ovh_last);
	cov_febe_auto: cover property (fe_ds3 && febe_auto);
	cov_rei_insert: cover property (inv_rei);

endmodule

// [shared/toei_pkg.sv]
/*
 * Constants for the transmit overhead error insertion block: register map,
 * field positions, reset values, framing modes and overhead position codes.
 * Assumes the frame generator marks every overhead bit with one position code.
 */
package toei_pkg;

	// Register byte offsets
	localparam logic [3:0] OFS_ERR_CTRL = 4'h0;
	localparam logic [3:0] OFS_CONFIG = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;

	// Bit positions in error_injection_control
	localparam int REQ_FRAME_BIT = 0;
	localparam int REQ_MFRAME_BIT = 1;
	localparam int REQ_PARITY = 2;
	localparam int REQ_PARITY_MIS = 3;
	localparam int REQ_PATH_PARITY = 4;
	localparam int REQ_REMOTE_ALARM = 5;
	localparam int REQ_XBIT_MIS = 6;
	localparam int REQ_FAR_END = 7;
	localparam int REQ_COUNT = 8;

	// Field positions in the configuration register
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_FEBE_AUTO = 2;
	localparam int CFG_CODE_LSB = 3;

	// Reset values, and the FEBE code sent on a seen error
	localparam logic [7:0] RST_ERR_CTRL = 8'h00;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic RST_FEBE_AUTO = 1'b0;
	localparam logic [2:0] RST_CODE = 3'h0;
	localparam logic [7:0] RST_INS_COUNT = 8'h00;
	localparam logic [2:0] FEBE_NO_ERR_CODE = 3'h7;

	// Framing modes
	typedef enum logic [1:0] {
		MODE_DS3_M13 = 2'h0,
		MODE_DS3_CBIT = 2'h1,
		MODE_E3_G751 = 2'h2,
		MODE_E3_G832 = 2'h3
	} toei_mode_t;

	// Overhead position codes supplied with each bit
	typedef enum logic [3:0] {
		OVH_NONE = 4'h0,
		OVH_F = 4'h1,
		OVH_M = 4'h2,
		OVH_P = 4'h3,
		OVH_CP = 4'h4,
		OVH_X = 4'h5,
		OVH_FEBE = 4'h6,
		OVH_FAS = 4'h7,
		OVH_ABIT = 4'h8,
		OVH_BIP = 4'h9,
		OVH_RDI = 4'ha,
		OVH_REI = 4'hb
	} toei_kind_t;

endpackage

// [tb/test_tx_overhead_error_inject.sv]
/*
 * Bench for toei_top: registers over Avalon-MM, insertion per mode, self-clear.
 * Assumes the line model echoes each output bit one cycle later.
 */
`timescale 1ns/100ps
module test_tx_overhead_error_inject;
	// Design and model signals
	logic ref_clk;
	logic rst;
	logic [3:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic tx_bit_in;
	logic tx_bit_valid;
	logic [3:0] ovh_kind;
	logic ovh_first;
	logic ovh_last;
	logic [1:0] ovh_idx;
	logic rx_err_detected;
	logic tx_bit_out;
	logic tx_bit_out_valid;
	logic rx_bit;
	logic rx_strobe;
	// Bench state
	int n_errors;
	int checks;
	int seed;
	logic [2:0] code;
	logic exp_bits[$];
	logic [31:0] exp_rd[$];

	toei_top i_toei_top (
		.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_bit_in(tx_bit_in),
		.tx_bit_valid(tx_bit_valid), .ovh_kind(ovh_kind), .ovh_first(ovh_first),
		.ovh_last(ovh_last), .ovh_idx(ovh_idx), .rx_err_detected(rx_err_detected),
		.tx_bit_out(tx_bit_out), .tx_bit_out_valid(tx_bit_out_valid)
	);
	toei_liu_model i_toei_liu_model (
		.ref_clk(ref_clk), .rst(rst), .line_bit(tx_bit_out), .line_valid(tx_bit_out_valid),
		.rx_bit(rx_bit), .rx_strobe(rx_strobe)
	);

	// 40 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string what);
		checks++;
		if (got !== want) begin
			n_errors++;
			$display("MISMATCH at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask

	// One bus cycle; the request stands until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] be);
		@(posedge ref_clk);
		tx_bit_valid <= 1'b0;
		avs_address <= a;
		avs_writedata <= w ? d : 32'h0;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		if (!w) exp_rd.push_back(d);
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d}, 4'h1);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] d);
		bus(1'b0, a, {24'h0, d}, 4'hf);
	endtask

	task automatic cfg(input toei_pkg::toei_mode_t m, input logic au, input logic [2:0] c);
		wr(toei_pkg::OFS_CONFIG, {2'h0, c, au, m});
	endtask

	// Back-to-back group of n bits; inv marks bits expected inverted, fen forces frc
	task automatic send(input toei_pkg::toei_kind_t k, input int n, input logic [15:0] inv,
			input logic [2:0] frc = 3'h0, input logic fen = 1'b0);
		logic b;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			b = 1'($random(seed));
			tx_bit_in <= b;
			tx_bit_valid <= 1'b1;
			ovh_kind <= k;
			ovh_first <= (i == 0);
			ovh_last <= (i == n - 1);
			ovh_idx <= i[1:0];
			exp_bits.push_back(fen ? frc[2 - i] : b ^ inv[i]);
		end
	endtask

	// Results are checked against the oldest note as they appear
	always @(posedge ref_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			cmp(avs_readdata, exp_rd.pop_front(), "register read");
		end
		if (rx_strobe === 1'b1) begin
			if (exp_bits.size() == 0) cmp(32'h1, 32'h0, "extra line bit");
			else cmp({31'h0, rx_bit}, {31'h0, exp_bits.pop_front()}, "line bit");
		end
	end

	// Watchdog; the run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		test_done();
	end

	initial begin
		seed = 32'h4d61;
		n_errors = 0;
		checks = 0;
		rst = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		tx_bit_in = 1'b0;
		tx_bit_valid = 1'b0;
		ovh_kind = 4'h0;
		ovh_first = 1'b0;
		ovh_last = 1'b0;
		ovh_idx = 2'h0;
		rx_err_detected = 1'b0;
		code = 3'h0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		// Reset values, unmapped place, write with lane 0 off
		rd(toei_pkg::OFS_ERR_CTRL, toei_pkg::RST_ERR_CTRL);
		rd(toei_pkg::OFS_CONFIG, 8'h00);
		rd(toei_pkg::OFS_STATUS, toei_pkg::RST_INS_COUNT);
		rd(4'hc, 8'h00);
		bus(1'b1, toei_pkg::OFS_CONFIG, 32'h1, 4'h0);
		rd(toei_pkg::OFS_CONFIG, 8'h00);
		$display("test registers done");
		// DS3 single bits with two requests pending
		wr(toei_pkg::OFS_ERR_CTRL, 8'h03);
		send(toei_pkg::OVH_NONE, 4, 16'h0);
		send(toei_pkg::OVH_F, 1, 16'h1);
		rd(toei_pkg::OFS_ERR_CTRL, 8'h02);
		wr(toei_pkg::OFS_ERR_CTRL, 8'h00);
		rd(toei_pkg::OFS_ERR_CTRL, 8'h02);
		send(toei_pkg::OVH_F, 1, 16'h0);
		send(toei_pkg::OVH_M, 1, 16'h1);
		send(toei_pkg::OVH_M, 1, 16'h0);
		rd(toei_pkg::OFS_ERR_CTRL, 8'h00);
		$display("test ds3 single bits done");
		// Pair errors go first, the mismatch follows in the next pair
		wr(toei_pkg::OFS_ERR_CTRL, 8'h6c);
		send(toei_pkg::OVH_P, 2, 16'h3);
		send(toei_pkg::OVH_P, 2, 16'h1);
		send(toei_pkg::OVH_P, 2, 16'h0);
		send(toei_pkg::OVH_X, 2, 16'h3);
		send(toei_pkg::OVH_X, 2, 16'h1);
		send(toei_pkg::OVH_X, 2, 16'h0);
		rd(toei_pkg::OFS_ERR_CTRL, 8'h00);
		$display("test ds3 pairs done");
		// Path parity and far end wait in M13, act in C-bit mode
		wr(toei_pkg::OFS_ERR_CTRL, 8'h90);
		send(toei_pkg::OVH_CP, 3, 16'h0);
		send(toei_pkg::OVH_FEBE, 3, 16'h0);
		rd(toei_pkg::OFS_ERR_CTRL, 8'h90);
		cfg(toei_pkg::MODE_DS3_CBIT, 1'b0, 3'h0);
		send(toei_pkg::OVH_CP, 3, 16'h7);
		send(toei_pkg::OVH_FEBE, 3, 16'h7);
		rd(toei_pkg::OFS_ERR_CTRL, 8'h00);
		// Automatic far end code: programmed field, or no-error code on a seen error
		for (int j = 0; j < 3; j++) begin
			code = j[0] ? 3'h5 : 3'h2;
			cfg(toei_pkg::MODE_DS3_CBIT, 1'b1, code);
			rx_err_detected <= (j == 2);
			wr(toei_pkg::OFS_ERR_CTRL, 8'h80);
			send(toei_pkg::OVH_FEBE, 3, 16'h0, (j == 2) ? toei_pkg::FEBE_NO_ERR_CODE : code, 1'b1);
			rd(toei_pkg::OFS_ERR_CTRL, 8'h00);
		end
		rx_err_detected <= 1'b0;
		$display("test c-bit done");
		// G.751 with two requests that have no meaning there
		cfg(toei_pkg::MODE_E3_G751, 1'b0, 3'h0);
		wr(toei_pkg::OFS_ERR_CTRL, 8'h65);
		send(toei_pkg::OVH_FAS, 10, 16'h1);
		send(toei_pkg::OVH_ABIT, 1, 16'h1);
		send(toei_pkg::OVH_ABIT, 1, 16'h0);
		rd(toei_pkg::OFS_ERR_CTRL, 8'h44);
		$display("test g751 done");
		// G.832 picks up the pending parity request
		cfg(toei_pkg::MODE_E3_G832, 1'b0, 3'h0);
		wr(toei_pkg::OFS_ERR_CTRL, 8'ha1);
		rd(toei_pkg::OFS_ERR_CTRL, 8'he5);
		send(toei_pkg::OVH_FAS, 16, 16'h1);
		send(toei_pkg::OVH_BIP, 8, 16'h1);
		send(toei_pkg::OVH_RDI, 1, 16'h1);
		send(toei_pkg::OVH_REI, 1, 16'h1);
		rd(toei_pkg::OFS_ERR_CTRL, 8'h40);
		cfg(toei_pkg::MODE_DS3_M13, 1'b0, 3'h0);
		send(toei_pkg::OVH_X, 2, 16'h1);
		rd(toei_pkg::OFS_ERR_CTRL, 8'h00);
		// Eighteen completions so far, each in a cycle of its own
		rd(toei_pkg::OFS_STATUS, 8'h12);
		$display("test g832 done");
		repeat (4) @(posedge ref_clk);
		cmp(exp_bits.size(), 0, "bits not received");
		test_done();
	end
endmodule

// [tb/toei_liu_model.sv]
/*
 * Line interface model that receives the transmitted bit stream.
 * Assumes bits arrive on ref_clk with a per-cycle valid.
 */
`timescale 1ns/100ps
module toei_liu_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Line side
	input wire logic line_bit,
	input wire logic line_valid,
	// Recovered bits
	output logic rx_bit,
	output logic rx_strobe
);
	// Capture each bit; between bits show the inverse so stale data never matches
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_bit <= 1'b0;
			rx_strobe <= 1'b0;
		end else begin
			rx_strobe <= line_valid;
			rx_bit <= line_valid ? line_bit : ~rx_bit;
		end
	end
endmodule
